/* shared/lpe_defs.svh */
`ifndef LPE_DEFS_SVH
`define LPE_DEFS_SVH
// Operation
// - While a lookup parity error is flagged, no later lookup may change any field of the info register.
// - While no lookup parity error is flagged, software writes to the info register are ignored.
// - The high byte field holds the upper byte of a 16-bit destination ID from the failing lookup.
// - For a small, single-byte destination ID the whole 8-bit ID goes into the high byte field.
// - The low byte field holds the lower byte of a 16-bit destination ID from the failing lookup.
// - For a small destination ID the low byte field is unused and carries no meaning.
// - The large ID flag is set when the failing packet's transport type code is not zero.
// - Once software clears the parity error flag, the captured ID fields are no longer valid.
// - The captured parity field holds the parity bit read from the table for the failing entry.
// - The mapped flag reads 0 for an unmapped entry, and the port field then holds all ones.
// - The mapped flag reads 1 for a mapped entry, and the port field gives the target port.
// - The port field holds the routing port of the failing entry, all ones when unmapped.

// Register offsets
`define LPE_OFS_INFO      8'h10
`define LPE_OFS_STATUS    8'h18
`define LPE_OFS_MASK      8'h1C
`define LPE_OFS_COUNT     8'h20

// Reset values
`define LPE_INFO_RESET    32'h0000_0000
`define LPE_STATUS_RESET  2'h0
`define LPE_MASK_RESET    2'h0
`define LPE_COUNT_RESET   8'h00

// Info register field positions
`define LPE_HI_MSB        31
`define LPE_HI_LSB        24
`define LPE_LO_MSB        23
`define LPE_LO_LSB        16
`define LPE_LARGE_BIT     15
`define LPE_PAR_BIT       7
`define LPE_MAP_BIT       6
`define LPE_PORT_MSB      3
`define LPE_PORT_LSB      0

// Writable bits of the info register; reserved bits read zero
`define LPE_INFO_WMASK    32'hFFFF_80CF

// Field values
`define LPE_PORT_UNMAPPED 4'hF
`define LPE_TT_SMALL      2'h0
`define LPE_LO_UNUSED     8'h00

// Status bit positions
`define LPE_ST_ERR        0
`define LPE_ST_OVR        1
`endif

/* shared/lpe_pkg.sv */
package lpe_pkg;
   // Freeze state of the capture register
   typedef enum logic {
      LPE_ARMED,
      LPE_FROZEN
   } lpe_state_type;

   typedef logic [31:0] lpe_word_type;
endpackage : lpe_pkg

/* shared/lpe_cap_if.sv */
`timescale 1ns/1ps
`default_nettype none
// Lookup details in, packed capture word out
interface lpe_cap_if;
   logic [15:0]         dest_id;
   logic [1:0]          tt;
   logic                parity;
   logic                mapped;
   logic [3:0]          port;
   lpe_pkg::lpe_word_type word;

   modport src  (output dest_id, output tt, output parity, output mapped, output port, input word);
   modport pack (input dest_id, input tt, input parity, input mapped, input port, output word);
endinterface : lpe_cap_if
`default_nettype wire

/* logic/lpe_field_pack.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpe_defs.svh"
module lpe_field_pack (
   lpe_cap_if.pack cap
);
   // Lay lookup details into the register layout
   always_comb begin
      cap.word = `LPE_INFO_RESET;
      if (cap.tt == `LPE_TT_SMALL) begin
         cap.word[`LPE_HI_MSB:`LPE_HI_LSB] = cap.dest_id[7:0];
         cap.word[`LPE_LO_MSB:`LPE_LO_LSB] = `LPE_LO_UNUSED;
      end else begin
         cap.word[`LPE_HI_MSB:`LPE_HI_LSB] = cap.dest_id[15:8];
         cap.word[`LPE_LO_MSB:`LPE_LO_LSB] = cap.dest_id[7:0];
      end
      cap.word[`LPE_LARGE_BIT] = (cap.tt != `LPE_TT_SMALL);
      cap.word[`LPE_PAR_BIT]   = cap.parity;
      // Mapped flag is stored as read even though it may be corrupt
      cap.word[`LPE_MAP_BIT]   = cap.mapped;
      if (cap.mapped) begin
         cap.word[`LPE_PORT_MSB:`LPE_PORT_LSB] = cap.port;
      end else begin
         cap.word[`LPE_PORT_MSB:`LPE_PORT_LSB] = `LPE_PORT_UNMAPPED;
      end
   end
endmodule : lpe_field_pack
`default_nettype wire

/* logic/lpe_capture.sv */
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "lpe_defs.svh"
module lpe_capture #(
   parameter int ADDR_W  = 8,
   parameter int COUNT_W = 8
) (
   input  wire logic              mclk,
   input  wire logic              rst_b,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [31:0]       reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output var  logic [31:0]       reg_rdata_q,
   input  wire logic              lk_valid,
   input  wire logic              lk_par_err,
   input  wire logic [15:0]       lk_dest_id,
   input  wire logic [1:0]        lk_tt,
   input  wire logic              lk_parity,
   input  wire logic              lk_mapped,
   input  wire logic [3:0]        lk_port,
   output var  logic              par_err_flag_q,
   output var  logic              irq_q
);

   // Freeze state, info word and interrupt registers
   lpe_pkg::lpe_state_type state_q;
   lpe_pkg::lpe_state_type state_d;
   lpe_pkg::lpe_word_type  info_q;
   lpe_pkg::lpe_word_type  info_d;
   logic [1:0]             ovr_q;
   logic [1:0]             ovr_d;
   logic [1:0]             mask_q;
   logic [1:0]             mask_d;
   logic [1:0]             status_d;
   logic [COUNT_W-1:0]     count_q;
   logic [COUNT_W-1:0]     count_d;
   logic [31:0]            rdata_d;

   // Decoded accesses
   logic                   hit_info;
   logic                   hit_status;
   logic                   hit_mask;
   logic                   hit_count;
   logic                   wr_info;
   logic                   rd_status;
   logic                   wr_mask;
   logic                   err_event;
   logic                   capture;

   lpe_cap_if cap ();

   // Present the current lookup to the packer
   assign cap.dest_id = lk_dest_id;
   assign cap.tt      = lk_tt;
   assign cap.parity  = lk_parity;
   assign cap.mapped  = lk_mapped;
   assign cap.port    = lk_port;

   lpe_field_pack u_pack (
      .cap (cap)
   );

   // Address decode on all ADDR_W address bits
   assign hit_info   = (reg_addr == ADDR_W'(`LPE_OFS_INFO));
   assign hit_status = (reg_addr == ADDR_W'(`LPE_OFS_STATUS));
   assign hit_mask   = (reg_addr == ADDR_W'(`LPE_OFS_MASK));
   assign hit_count  = (reg_addr == ADDR_W'(`LPE_OFS_COUNT));
   assign wr_info    = reg_wr && hit_info;
   assign rd_status  = reg_rd && hit_status;
   assign wr_mask    = reg_wr && hit_mask;

   // A parity error reported by the routing lookup this cycle
   assign err_event  = lk_valid && lk_par_err;

   // Only the first error after the flag was cleared is recorded
   assign capture    = err_event && (state_q == lpe_pkg::LPE_ARMED);

   // Freeze state: a status read clears it, a new error sets it, set wins
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         lpe_pkg::LPE_ARMED: begin
            if (capture) begin
               state_d = lpe_pkg::LPE_FROZEN;
            end
         end
         lpe_pkg::LPE_FROZEN: begin
            // Clearing the flag releases the fields; their old content is stale
            if (rd_status) begin
               state_d = lpe_pkg::LPE_ARMED;
            end
            if (err_event) begin
               state_d = lpe_pkg::LPE_FROZEN;
            end
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_q <= lpe_pkg::LPE_ARMED;
      end else begin
         state_q <= state_d;
      end
   end

   // Info word: lookups load it only when armed, software only when frozen
   always_comb begin
      info_d = info_q;
      if (capture) begin
         info_d = cap.word;
      end else if (wr_info && (state_q == lpe_pkg::LPE_FROZEN)) begin
         // Frozen against lookups, but software may still patch the fields
         info_d = reg_wdata & `LPE_INFO_WMASK;
      end
      // An unflagged write falls through and leaves the word as it was
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         info_q <= `LPE_INFO_RESET;
      end else begin
         info_q <= info_d;
      end
   end

   // Overrun: an error that arrives while frozen is lost, so note it
   always_comb begin
      ovr_d = ovr_q;
      if (rd_status) begin
         ovr_d = `LPE_STATUS_RESET;
      end
      // Set wins over the read clear in the same cycle
      if (err_event && (state_q == lpe_pkg::LPE_FROZEN)) begin
         ovr_d[`LPE_ST_OVR] = 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         ovr_q <= `LPE_STATUS_RESET;
      end else begin
         ovr_q <= ovr_d;
      end
   end

   // Mask register, same layout as the status
   always_comb begin
      mask_d = mask_q;
      if (wr_mask) begin
         mask_d = reg_wdata[1:0];
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         mask_q <= `LPE_MASK_RESET;
      end else begin
         mask_q <= mask_d;
      end
   end

   // Saturating error count, so a storm of errors never wraps to zero
   always_comb begin
      count_d = count_q;
      if (err_event && (count_q != {COUNT_W{1'b1}})) begin
         count_d = count_q + COUNT_W'(1);
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         count_q <= COUNT_W'(`LPE_COUNT_RESET);
      end else begin
         count_q <= count_d;
      end
   end

   // Status view: error flag from the freeze state, overrun from its own bit
   always_comb begin
      status_d              = ovr_d;
      status_d[`LPE_ST_ERR] = (state_d == lpe_pkg::LPE_FROZEN);
   end

   // Interrupt and flag come from the next-state values so they stay on flops
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         irq_q          <= 1'b0;
         par_err_flag_q <= 1'b0;
      end else begin
         irq_q          <= |(status_d & mask_d);
         par_err_flag_q <= (state_d == lpe_pkg::LPE_FROZEN);
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = 32'h0000_0000;
      if (reg_rd) begin
         if (hit_info) begin
            rdata_d = info_q;
         end else if (hit_status) begin
            rdata_d[1:0] = {ovr_q[`LPE_ST_OVR], (state_q == lpe_pkg::LPE_FROZEN)};
         end else if (hit_mask) begin
            rdata_d[1:0] = mask_q;
         end else if (hit_count) begin
            rdata_d[COUNT_W-1:0] = count_q;
         end
      end
   end

   // Read data stands for exactly the cycle after the strobe
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_q <= 32'h0000_0000;
      end else begin
         reg_rdata_q <= rdata_d;
      end
   end

endmodule : lpe_capture
`default_nettype wire

/* testbench/lpe_capture_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpe_defs.svh"
module lpe_capture_assertions #(
   parameter int ADDR_W = 8
) (
   input wire logic              mclk,
   input wire logic              rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [31:0]       reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic [31:0]       reg_rdata_q,
   input wire logic              lk_valid,
   input wire logic              lk_par_err,
   input wire logic [15:0]       lk_dest_id,
   input wire logic [1:0]        lk_tt,
   input wire logic              lk_parity,
   input wire logic              lk_mapped,
   input wire logic [3:0]        lk_port,
   input wire logic              par_err_flag_q,
   input wire logic              irq_q
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_b);

   // Steps of a capture and of its release by a status read
   sequence s_err;
      lk_valid && lk_par_err;
   endsequence
   sequence s_status_rd;
      reg_rd && reg_addr == `LPE_OFS_STATUS;
   endsequence

   property p_capture;
      s_err ##0 !par_err_flag_q |=> par_err_flag_q;
   endproperty
   property p_hold;
      par_err_flag_q && !(reg_rd && reg_addr == `LPE_OFS_STATUS) |=> par_err_flag_q;
   endproperty
   property p_quiet;
      !par_err_flag_q && !(lk_valid && lk_par_err) |=> !par_err_flag_q;
   endproperty
   property p_clear;
      s_status_rd ##0 !(lk_valid && lk_par_err) |=> !par_err_flag_q && !irq_q;
   endproperty
   // Read data only stands in the cycle after a read
   property p_idle;
      !reg_rd |=> reg_rdata_q == 32'h0;
   endproperty
   property p_reserved;
      reg_rd && reg_addr == `LPE_OFS_INFO |=> (reg_rdata_q & ~`LPE_INFO_WMASK) == 32'h0;
   endproperty
   property p_unmapped;
      reg_rd && reg_addr == `LPE_OFS_INFO && par_err_flag_q ##1 !reg_rdata_q[`LPE_MAP_BIT]
         |-> reg_rdata_q[3:0] == `LPE_PORT_UNMAPPED;
   endproperty
   property p_irq;
      irq_q |-> par_err_flag_q;
   endproperty

   a_capture: assert property (p_capture) else $error("flag not raised by lookup error");
   a_hold: assert property (p_hold) else $error("flag dropped without status read");
   a_quiet: assert property (p_quiet) else $error("flag raised without lookup error");
   a_clear: assert property (p_clear) else $error("status read did not clear flag");
   a_idle: assert property (p_idle) else $error("read data not zero when idle");
   a_reserved: assert property (p_reserved) else $error("reserved info bits not zero");
   a_unmapped: assert property (p_unmapped) else $error("unmapped entry port not all ones");
   a_irq: assert property (p_irq) else $error("interrupt without flagged error");
endmodule : lpe_capture_assertions
`default_nettype wire

/* testbench/lpe_capture_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "lpe_defs.svh"
module lpe_capture_tb;
   logic        mclk, rst_b, reg_wr, reg_rd, lk_valid, lk_par_err, lk_parity, lk_mapped;
   logic        par_err_flag_q, irq_q;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata_q;
   logic [15:0] lk_dest_id;
   logic [1:0]  lk_tt;
   logic [3:0]  lk_port, i;
   int          mismatches, compares, cycles;

   lpe_capture lpe_capture_i (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .lk_valid(lk_valid),
      .lk_par_err(lk_par_err), .lk_dest_id(lk_dest_id), .lk_tt(lk_tt), .lk_parity(lk_parity),
      .lk_mapped(lk_mapped), .lk_port(lk_port), .par_err_flag_q(par_err_flag_q), .irq_q(irq_q));

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   task automatic conclude;
      $display("Mismatches %0d, compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Each access leaves an idle cycle so a strobe is never reassigned in one step
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      @(posedge mclk);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 check(reg_rdata_q, exp);
      @(posedge mclk);
   endtask : rdc

   // One lookup; the flag and interrupt show their new values in the cycle after it
   task automatic look(input logic pe, input logic [15:0] id, input logic [1:0] tt, input logic par,
                       input logic map, input logic [3:0] port, input logic [1:0] fl);
      {lk_valid, lk_par_err, lk_dest_id, lk_tt, lk_parity, lk_mapped, lk_port} <= {1'b1, pe, id, tt, par, map, port};
      @(posedge mclk);
      {lk_valid, lk_par_err, lk_dest_id} <= {2'h0, ~id};
      #1 check({30'h0, irq_q, par_err_flag_q}, {30'h0, fl});
   endtask : look

   // Expected info word for one captured lookup
   function automatic logic [31:0] info(input logic [15:0] id, input logic [1:0] tt, input logic par,
                                        input logic map, input logic [3:0] port);
      info = {(tt == 2'h0) ? id[7:0] : id[15:8], (tt == 2'h0) ? 8'h00 : id[7:0], tt != 2'h0, 7'h00,
              par, map, 2'h0, map ? port : 4'hF};
   endfunction : info

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 2000) begin
         mismatches++;
         conclude();
      end
   end

   initial begin
      {rst_b, reg_wr, reg_rd, lk_valid, lk_par_err, lk_parity, lk_mapped} <= 7'h00;
      {reg_addr, reg_wdata, lk_dest_id, lk_tt, lk_port} <= 62'h0;
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      // Reset state, an unmapped address and an info write while nothing is flagged
      rdc(`LPE_OFS_INFO, `LPE_INFO_RESET);
      rdc(8'h04, 32'h0);
      wr(`LPE_OFS_INFO, 32'hFFFF_FFFF);
      rdc(`LPE_OFS_INFO, 32'h0);
      wr(`LPE_OFS_MASK, 32'h3);
      rdc(`LPE_OFS_MASK, 32'h3);
      look(1'b0, 16'h0042, 2'h0, 1'b0, 1'b1, 4'h2, 2'h0);
      check({31'h0, par_err_flag_q}, 32'h0);
      look(1'b1, 16'h1234, 2'h1, 1'b1, 1'b1, 4'h5, 2'h3);
      check({30'h0, irq_q, par_err_flag_q}, 32'h3);
      // A second error while frozen must not touch the capture
      look(1'b1, 16'hBEEF, 2'h0, 1'b0, 1'b0, 4'h1, 2'h3);
      rdc(`LPE_OFS_INFO, info(16'h1234, 2'h1, 1'b1, 1'b1, 4'h5));
      wr(`LPE_OFS_INFO, 32'hFFFF_FFFF);
      rdc(`LPE_OFS_INFO, `LPE_INFO_WMASK);
      rdc(`LPE_OFS_STATUS, 32'h3);
      #1 check({30'h0, irq_q, par_err_flag_q}, 32'h0);
      // Every transport type, mapped and unmapped entries; the mapped flag is only read back as stored
      for (i = 4'h0; i < 4'h4; i++) begin
         look(1'b1, {12'hA5C, i}, i[1:0], i[1], i[0], i + 4'h6, 2'h3);
         rdc(`LPE_OFS_INFO, info({12'hA5C, i}, i[1:0], i[1], i[0], i + 4'h6));
         rdc(`LPE_OFS_STATUS, 32'h1);
      end
      // Masked error flags but does not interrupt
      wr(`LPE_OFS_MASK, 32'h0);
      look(1'b1, 16'h0101, 2'h2, 1'b0, 1'b1, 4'h0, 2'h1);
      check({30'h0, irq_q, par_err_flag_q}, 32'h1);
      rdc(`LPE_OFS_STATUS, 32'h1);
      // Overrun alone raises the interrupt when only its mask bit is set
      wr(`LPE_OFS_MASK, 32'h2);
      look(1'b1, 16'h0202, 2'h1, 1'b0, 1'b1, 4'h3, 2'h1);
      look(1'b1, 16'h0303, 2'h1, 1'b1, 1'b1, 4'h4, 2'h3);
      rdc(`LPE_OFS_INFO, info(16'h0202, 2'h1, 1'b0, 1'b1, 4'h3));
      rdc(`LPE_OFS_STATUS, 32'h3);
      // Count is read-only; a write must not disturb it
      wr(`LPE_OFS_COUNT, 32'hFF);
      rdc(`LPE_OFS_COUNT, 32'h9);
      conclude();
   end
endmodule : lpe_capture_tb

bind lpe_capture lpe_capture_assertions #(.ADDR_W(ADDR_W)) lpe_capture_assertions_i (.mclk(mclk), .rst_b(rst_b),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
   .lk_valid(lk_valid), .lk_par_err(lk_par_err), .lk_dest_id(lk_dest_id), .lk_tt(lk_tt), .lk_parity(lk_parity),
   .lk_mapped(lk_mapped), .lk_port(lk_port), .par_err_flag_q(par_err_flag_q), .irq_q(irq_q));
`default_nettype wire
